// file: hdl/spi_prot_pkg.sv
/*
  Shared constants for the single-bit serial protection command decoder:
  opcodes, region sizes, reset values, link timing and state types.
  Assumes both ends and the testbench import it.
*/
package spi_prot_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] suspend_operation_cmd = 8'hb0;
  localparam logic [7:0] resume_operation_cmd = 8'h7a;
  localparam logic [7:0] program_secure_region_cmd = 8'h42;
  localparam logic [7:0] read_secure_region_cmd = 8'h4b;
  localparam logic [7:0] read_dynamic_protect_cmd = 8'he0;
  localparam logic [7:0] write_dynamic_protect_cmd = 8'he1;
  localparam logic [7:0] read_persistent_protect_cmd = 8'he2;
  localparam logic [7:0] program_persistent_protect_cmd = 8'he3;
  localparam logic [7:0] erase_persistent_protect_cmd = 8'he4;
  localparam logic [7:0] clear_protect_lock_cmd = 8'ha6;
  localparam logic [7:0] read_protect_lock_cmd = 8'ha7;
  localparam logic [7:0] password_unlock_cmd = 8'he9;

  // ****************************************
  // storage layout and reset values
  // ****************************************
  localparam int OTP_BYTES = 1024;
  localparam int OTP_AW = 10;
  localparam int SECTOR_COUNT = 128;
  localparam int SECTOR_LSB = 18;
  localparam int SECTOR_AW = 7;
  localparam logic [3:0] ADDR_LAST = 4'h3;
  localparam logic [3:0] PWD_LAST = 4'h7;
  localparam logic [3:0] ADDR_HDR = 4'h5;
  localparam logic [3:0] CMD_HDR = 4'h1;
  // value arbitrary, replace per product
  localparam logic [63:0] HIDDEN_PASSWORD = 64'h0123_4567_89ab_cdef;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic PROTECT_RESET = 1'b1;

  // ****************************************
  // link timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_HALF_NS = 160;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {
    st_cmd = 3'b000,
    st_addr = 3'b001,
    st_din = 3'b010,
    st_dout = 3'b011,
    st_pwd = 3'b100,
    st_exec = 3'b101,
    st_ignore = 3'b110
  } flash_state_type;

  typedef enum logic [2:0] {
    h_idle = 3'b000,
    h_setup = 3'b001,
    h_low = 3'b010,
    h_high = 3'b011,
    h_hold = 3'b100,
    h_gap = 3'b101
  } host_state_type;

endpackage

// file: hdl/spi_link_if.sv
/*
  Four-wire serial link between the controller and the flash end.
  Assumes the controller makes the serial clock; all wires one-way.
*/
`timescale 1ns/100ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;

  // flash end receives select, clock and data in
  modport flash_end (input cs_n, input sck, input mosi, output miso);
  // controller end drives them
  modport ctrl_end (output cs_n, output sck, output mosi, input miso);
endinterface

// file: hdl/spi_prot_flash.sv
/*
  Flash-side decoder for suspend/resume, secure region and sector protection
  commands on a single-bit serial link, mode 0, opcode and address MSB first.
  Assumes clk_i is several times faster than the serial clock, which it
  samples through two flip-flops together with select and data in.
*/
`timescale 1ns/100ps
module spi_prot_flash (
  input wire logic clk_i,
  input wire logic resetn_i,
  spi_link_if.flash_end link,
  input wire logic op_busy_i,
  input wire logic [spi_prot_pkg::SECTOR_AW-1:0] sector_i,
  output logic sector_protected_o,
  output logic suspended_o,
  output logic lock_bit_o,
  output logic wel_o,
  output logic lockout_o
);
  import spi_prot_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [2:0] s1_reg, s2_reg;
  logic cs_d_reg, cs_d_next, sck_d_reg, sck_d_next;
  flash_state_type state_reg, state_next;
  logic [7:0] shift_reg, shift_next, cmd_reg, cmd_next, out_reg, out_next;
  logic [2:0] bit_reg, bit_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [31:0] addr_reg, addr_next;
  logic [63:0] pwd_reg, pwd_next;
  logic miso_reg, miso_next, wel_reg, wel_next, lock_reg, lock_next;
  logic susp_reg, susp_next, lockout_reg, lockout_next;
  logic [SECTOR_COUNT-1:0] dyb_reg, dyb_next, ppb_reg, ppb_next;
  logic [7:0] otp_mem [OTP_BYTES] = '{default: 8'hff};
  logic mem_we;
  logic [OTP_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic cs_s, sck_s, mosi_s, cs_act, cs_end, rise, fall;
  logic [7:0] byte_in;
  logic [31:0] addr_full, addr_inc;

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  // two stages per pin; only the second stage is looked at
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
    end else begin
      s1_reg <= {link.cs_n, link.sck, link.mosi};
      s2_reg <= s1_reg;
    end
  end

  assign cs_s = s2_reg[2];
  assign sck_s = s2_reg[1];
  assign mosi_s = s2_reg[0];
  assign cs_act = !cs_s;
  assign cs_end = cs_s && !cs_d_reg;
  assign rise = cs_act && sck_s && !sck_d_reg;
  assign fall = cs_act && !sck_s && sck_d_reg;
  assign byte_in = {shift_reg[6:0], mosi_s};
  assign addr_full = {addr_reg[23:0], byte_in};
  assign addr_inc = addr_reg + 32'h1;

  // ****************************************
  // helpers
  // ****************************************
  // answer byte for read commands; protect registers repeat per byte
  function automatic logic [7:0] read_value(input logic [7:0] c, input logic [31:0] a);
    logic [SECTOR_AW-1:0] sec;
    sec = a[SECTOR_LSB+:SECTOR_AW];
    case (c)
      read_secure_region_cmd: read_value = otp_mem[a[OTP_AW-1:0]];
      read_dynamic_protect_cmd: read_value = {8{dyb_reg[sec]}};
      read_persistent_protect_cmd: read_value = {8{ppb_reg[sec]}};
      read_protect_lock_cmd: read_value = {7'h00, lock_reg};
      default: read_value = 8'hff;
    endcase
  endfunction

  function automatic logic needs_wel(input logic [7:0] c);
    needs_wel = (c == program_secure_region_cmd) || (c == write_dynamic_protect_cmd)
      || (c == program_persistent_protect_cmd) || (c == erase_persistent_protect_cmd)
      || (c == clear_protect_lock_cmd);
  endfunction

  // ****************************************
  // command decoder
  // ****************************************
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    out_next = out_reg;
    bit_next = bit_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    pwd_next = pwd_reg;
    miso_next = miso_reg;
    wel_next = wel_reg;
    lock_next = lock_reg;
    susp_next = susp_reg;
    lockout_next = lockout_reg;
    dyb_next = dyb_reg;
    ppb_next = ppb_reg;
    cs_d_next = cs_s;
    sck_d_next = sck_s;
    mem_we = 1'b0;
    mem_wa = addr_reg[OTP_AW-1:0];
    mem_wd = 8'hff;
    if (!cs_act) begin
      state_next = st_cmd;
      bit_next = 3'h0;
      cnt_next = 4'h0;
      miso_next = 1'b0;
      // commands other than the secure region program take effect only when select rises after a whole frame
      if (cs_end && state_reg == st_exec) begin
        case (cmd_reg)
          write_enable_cmd: wel_next = 1'b1;
          suspend_operation_cmd: if (op_busy_i) susp_next = 1'b1;
          resume_operation_cmd: susp_next = 1'b0;
          write_dynamic_protect_cmd: begin
            if (wel_reg) dyb_next[addr_reg[SECTOR_LSB+:SECTOR_AW]] = shift_reg[0];
          end
          program_persistent_protect_cmd: begin
            if (wel_reg && lock_reg) ppb_next[addr_reg[SECTOR_LSB+:SECTOR_AW]] = 1'b0;
          end
          erase_persistent_protect_cmd: if (wel_reg && lock_reg) ppb_next = '1;
          clear_protect_lock_cmd: if (wel_reg) lock_next = 1'b0;
          password_unlock_cmd: begin
            if (pwd_reg == HIDDEN_PASSWORD) lock_next = 1'b1;
            else lockout_next = 1'b1;
          end
          default: ;
        endcase
      end
      if (cs_end && state_reg != st_cmd && needs_wel(cmd_reg)) wel_next = 1'b0;
    end else if (rise) begin
      shift_next = byte_in;
      bit_next = bit_reg + 3'h1;
      if (state_reg == st_exec) begin
        // surplus clocks after a complete command abort it
        state_next = st_ignore;
      end else if (bit_reg == 3'h7) begin
        case (state_reg)
          st_cmd: begin
            cmd_next = byte_in;
            if (lockout_reg) begin
              state_next = st_ignore;
            end else begin
              case (byte_in)
                write_enable_cmd, suspend_operation_cmd, resume_operation_cmd,
                erase_persistent_protect_cmd, clear_protect_lock_cmd: state_next = st_exec;
                read_protect_lock_cmd: begin
                  out_next = {7'h00, lock_reg};
                  state_next = st_dout;
                end
                program_secure_region_cmd, read_secure_region_cmd, read_dynamic_protect_cmd,
                write_dynamic_protect_cmd, read_persistent_protect_cmd,
                program_persistent_protect_cmd: state_next = st_addr;
                password_unlock_cmd: state_next = st_pwd;
                default: state_next = st_ignore;
              endcase
            end
          end
          st_addr: begin
            addr_next = addr_full;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == ADDR_LAST) begin
              case (cmd_reg)
                read_secure_region_cmd, read_dynamic_protect_cmd,
                read_persistent_protect_cmd: begin
                  out_next = read_value(cmd_reg, addr_full);
                  state_next = st_dout;
                end
                program_secure_region_cmd, write_dynamic_protect_cmd: state_next = st_din;
                default: state_next = st_exec;
              endcase
            end
          end
          st_din: begin
            if (cmd_reg == write_dynamic_protect_cmd) begin
              state_next = st_exec;
            end else begin
              // program secure byte, ones only clear
              mem_we = wel_reg;
              mem_wd = otp_mem[addr_reg[OTP_AW-1:0]] & byte_in;
              addr_next = addr_inc;
            end
          end
          st_dout: begin
            addr_next = addr_inc;
            out_next = read_value(cmd_reg, addr_inc);
          end
          st_pwd: begin
            // password arrives least significant byte first
            pwd_next = {byte_in, pwd_reg[63:8]};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == PWD_LAST) state_next = st_exec;
          end
          default: ;
        endcase
      end
    end else if (fall && state_reg == st_dout) begin
      miso_next = out_reg[7];
      out_next = {out_reg[6:0], 1'b0};
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= st_cmd;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      out_reg <= 8'h00;
      bit_reg <= 3'h0;
      cnt_reg <= 4'h0;
      addr_reg <= 32'h0;
      pwd_reg <= 64'h0;
      miso_reg <= 1'b0;
      wel_reg <= 1'b0;
      lock_reg <= LOCK_RESET;
      susp_reg <= 1'b0;
      lockout_reg <= 1'b0;
      dyb_reg <= {SECTOR_COUNT{PROTECT_RESET}};
      ppb_reg <= {SECTOR_COUNT{PROTECT_RESET}};
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      out_reg <= out_next;
      bit_reg <= bit_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      pwd_reg <= pwd_next;
      miso_reg <= miso_next;
      wel_reg <= wel_next;
      lock_reg <= lock_next;
      susp_reg <= susp_next;
      lockout_reg <= lockout_next;
      dyb_reg <= dyb_next;
      ppb_reg <= ppb_next;
      cs_d_reg <= cs_d_next;
      sck_d_reg <= sck_d_next;
    end
  end

  // region starts erased (all ones) and keeps its contents across reset
  always_ff @(posedge clk_i) begin
    if (mem_we) otp_mem[mem_wa] <= mem_wd;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.miso = miso_reg;
  assign sector_protected_o = !dyb_reg[sector_i] || !ppb_reg[sector_i];
  assign suspended_o = susp_reg;
  assign lock_bit_o = lock_reg;
  assign wel_o = wel_reg;
  assign lockout_o = lockout_reg;

endmodule

// file: hdl/spi_prot_host.sv
/*
  Controller end: frames one command (opcode, optional four address bytes,
  write bytes, read bytes) on the single-bit link, mode 0.
  Assumes the user holds start_i inputs stable in the start cycle and
  presents the next write byte before wr_take_o pulses.
*/
`timescale 1ns/100ps
module spi_prot_host (
  input wire logic clk_i,
  input wire logic resetn_i,
  spi_link_if.ctrl_end link,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [31:0] addr_i,
  input wire logic addr_en_i,
  input wire logic [7:0] wr_count_i,
  input wire logic [7:0] rd_count_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_take_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o
);
  import spi_prot_pkg::*;

  // ****************************************
  // state
  // ****************************************
  host_state_type state_reg, state_next;
  logic [7:0] div_reg, div_next, tx_reg, tx_next, rx_reg, rx_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic [2:0] bit_reg, bit_next;
  logic [9:0] idx_reg, idx_next, total_reg, total_next, wr_end_reg, wr_end_next;
  logic [9:0] hdr_reg, hdr_next;
  logic [31:0] addr_reg, addr_next;
  logic cs_n_reg, cs_n_next, sck_reg, sck_next, mosi_reg, mosi_next;
  logic take_reg, take_next, rdv_reg, rdv_next;
  logic m1_reg, m2_reg, tick;
  logic [9:0] nidx;
  logic [7:0] rx_full;

  // data in from the far end passes two stages before use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m1_reg <= 1'b0;
      m2_reg <= 1'b0;
    end else begin
      m1_reg <= link.miso;
      m2_reg <= m1_reg;
    end
  end

  // half-period enable; sampling at the falling edge leaves room for
  // the far end's synchroniser delay
  assign tick = div_reg == 8'(SCK_HALF_CYC - 1);
  assign nidx = idx_reg + 10'h1;
  assign rx_full = {rx_reg[6:0], m2_reg};

  // ****************************************
  // frame sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    div_next = tick ? 8'h00 : div_reg + 8'h1;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rd_data_next = rd_data_reg;
    bit_next = bit_reg;
    idx_next = idx_reg;
    total_next = total_reg;
    wr_end_next = wr_end_reg;
    hdr_next = hdr_reg;
    addr_next = addr_reg;
    cs_n_next = cs_n_reg;
    sck_next = sck_reg;
    mosi_next = mosi_reg;
    take_next = 1'b0;
    rdv_next = 1'b0;
    case (state_reg)
      h_idle: begin
        if (start_i) begin
          hdr_next = addr_en_i ? 10'(ADDR_HDR) : 10'(CMD_HDR);
          wr_end_next = (addr_en_i ? 10'(ADDR_HDR) : 10'(CMD_HDR)) + 10'(wr_count_i);
          total_next = (addr_en_i ? 10'(ADDR_HDR) : 10'(CMD_HDR)) + 10'(wr_count_i)
            + 10'(rd_count_i);
          addr_next = addr_i;
          idx_next = 10'h0;
          bit_next = 3'h0;
          tx_next = opcode_i;
          mosi_next = opcode_i[7];
          cs_n_next = 1'b0;
          state_next = h_setup;
        end
      end
      h_setup, h_low: begin
        if (tick) begin
          sck_next = 1'b1;
          state_next = h_high;
        end
      end
      h_high: begin
        if (tick) begin
          sck_next = 1'b0;
          rx_next = rx_full;
          bit_next = bit_reg + 3'h1;
          state_next = h_low;
          if (bit_reg == 3'h7) begin
            if (idx_reg >= wr_end_reg) begin
              rd_data_next = rx_full;
              rdv_next = 1'b1;
            end
            idx_next = nidx;
            if (nidx == total_reg) begin
              state_next = h_hold;
            end else if (nidx < hdr_reg) begin
              // address bytes leave most significant first
              tx_next = addr_reg[31:24];
              mosi_next = addr_reg[31];
              addr_next = {addr_reg[23:0], 8'h00};
            end else if (nidx < wr_end_reg) begin
              tx_next = wr_data_i;
              mosi_next = wr_data_i[7];
              take_next = 1'b1;
            end else begin
              tx_next = 8'h00;
              mosi_next = 1'b0;
            end
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            mosi_next = tx_reg[6];
          end
        end
      end
      h_hold: begin
        if (tick) begin
          cs_n_next = 1'b1;
          state_next = h_gap;
        end
      end
      h_gap: if (tick) state_next = h_idle;
      default: state_next = h_idle;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= h_idle;
      div_reg <= 8'h00;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      bit_reg <= 3'h0;
      idx_reg <= 10'h0;
      total_reg <= 10'h0;
      wr_end_reg <= 10'h0;
      hdr_reg <= 10'h0;
      addr_reg <= 32'h0;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      take_reg <= 1'b0;
      rdv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rd_data_reg <= rd_data_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      total_reg <= total_next;
      wr_end_reg <= wr_end_next;
      hdr_reg <= hdr_next;
      addr_reg <= addr_next;
      cs_n_reg <= cs_n_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      take_reg <= take_next;
      rdv_reg <= rdv_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.mosi = mosi_reg;
  assign wr_take_o = take_reg;
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rdv_reg;
  assign busy_o = state_reg != h_idle;

endmodule

// file: verification/spi_link_properties.sv
/*
  Timing properties of the four-wire serial link between the two ends.
  Assumes clk_i samples every wire and the controller makes sck.
*/
`timescale 1ns/100ps
module spi_link_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso
);
  logic [7:0] rise_count_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ****************************************
  // helper logic
  // ****************************************
  // sck rises within the current frame, cleared between frames
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_count_reg <= 8'h00;
    end else if (cs_n) begin
      rise_count_reg <= 8'h00;
    end else if ($rose(sck)) begin
      rise_count_reg <= rise_count_reg + 8'h01;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |->
    (rise_count_reg[2:0] == 3'h0) && (rise_count_reg != 8'h00))
    else $error("frame ended off a byte boundary");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("sck moved with select high");
  AST_FIRST_EDGE: assert property ($fell(cs_n) |-> !sck ##[1:5] sck)
    else $error("first sck rise late after select");
  AST_MOSI_STEADY: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi changed while sck high");
  AST_SELECT_GAP: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select high time too short");
  AST_MISO_STEADY: assert property (!cs_n && sck && $past(sck) |-> $stable(miso))
    else $error("miso changed while sck high");
  AST_MISO_IDLE: assert property (cs_n [*5] |-> !miso)
    else $error("miso not low between frames");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*4])
    else $error("sck high phase too short");
  AST_SCK_LOW: assert property ($fell(sck) |-> !sck [*4])
    else $error("sck low phase too short");

  // short frames, address frames and read answers
  cover property ($rose(cs_n) && rise_count_reg == 8'h08);
  cover property ($rose(cs_n) && rise_count_reg == 8'h30);
  cover property (!cs_n && miso);
endmodule

// file: verification/testbench.sv
/*
  Self-checking bench: controller end drives flash end over the link.
  Assumes both ends and the link properties compile alongside.
*/
`timescale 1ns/100ps
module testbench;
  import spi_prot_pkg::*;
  logic clk_i, resetn_i, start_i, addr_en_i, wr_take_o, rd_valid_o, busy_o, op_busy_i;
  logic sector_protected_o, suspended_o, lock_bit_o, wel_o, lockout_o;
  logic [7:0] opcode_i, wr_count_i, rd_count_i, wr_data_i, rd_data_o;
  logic [31:0] addr_i, seed, a;
  logic [6:0] sector_i, s;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];
  int widx, ridx, errors, total_checks;

  spi_link_if link ();
  spi_prot_host u_spi_prot_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
    .start_i(start_i), .opcode_i(opcode_i), .addr_i(addr_i), .addr_en_i(addr_en_i),
    .wr_count_i(wr_count_i), .rd_count_i(rd_count_i), .wr_data_i(wr_data_i),
    .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .busy_o(busy_o));
  spi_prot_flash u_spi_prot_flash (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
    .op_busy_i(op_busy_i), .sector_i(sector_i), .sector_protected_o(sector_protected_o),
    .suspended_o(suspended_o), .lock_bit_o(lock_bit_o), .wel_o(wel_o), .lockout_o(lockout_o));
  spi_link_properties u_spi_link_properties (.clk_i(clk_i), .resetn_i(resetn_i),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .miso(link.miso));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] sa(input logic [6:0] sec);
    return {7'h00, sec, 18'(rnd())};
  endfunction
  function automatic logic [7:0] prot_byte(input logic open);
    return open ? 8'hff : 8'h00;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // next write byte after each take; read bytes captured as they arrive
  always @(posedge clk_i) begin
    if (start_i) begin
      wr_data_i <= wbuf[0];
      widx <= 0;
      ridx <= 0;
    end
    if (wr_take_o) begin
      wr_data_i <= wbuf[(widx + 1) % 8];
      widx <= widx + 1;
    end
    if (rd_valid_o) begin
      rbuf[ridx % 8] <= rd_data_o;
      ridx <= ridx + 1;
    end
  end

  // one whole frame; returns once busy drops, select left high a while
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input logic ae,
                       input logic [7:0] wc, input logic [7:0] rc);
    int n;
    @(posedge clk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    addr_i <= ad;
    addr_en_i <= ae;
    wr_count_i <= wc;
    rd_count_i <= rc;
    @(posedge clk_i);
    start_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (busy_o !== 1'b0 && n < 3000);
    // a stuck frame counts against the run
    if (n >= 3000) errors++;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wen();
    frame(write_enable_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // watchdog, far beyond the expected run
  initial begin
    #(40 * 60000);
    errors++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'hb4c0e44a;
    errors = 0;
    total_checks = 0;
    {resetn_i, start_i, addr_en_i, op_busy_i} = 4'h0;
    {opcode_i, wr_count_i, rd_count_i} = 24'h0;
    addr_i = 32'h0;
    sector_i = 7'h00;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    // dynamic bits: first write lacks write-enable and must not land
    for (int i = 0; i < 4; i++) begin
      s = 7'(rnd());
      wbuf[0] = (i == 1) ? 8'h00 : 8'(rnd());
      if (i != 0) begin
        wen();
        chk({7'h00, wel_o}, 8'h01);
      end
      frame(write_dynamic_protect_cmd, sa(s), 1'b1, 8'h01, 8'h00);
      frame(read_dynamic_protect_cmd, sa(s), 1'b1, 8'h00, 8'h01);
      chk(rbuf[0], prot_byte(i == 0 || wbuf[0][0]));
      chk({7'h00, wel_o}, 8'h00);
      sector_i <= s;
      repeat (2) @(posedge clk_i);
      chk({7'h00, sector_protected_o}, {7'h00, i != 0 && !wbuf[0][0]});
    end
    $display("dynamic test done");
    s = 7'(rnd());
    wen();
    frame(program_persistent_protect_cmd, sa(s), 1'b1, 8'h00, 8'h00);
    frame(read_persistent_protect_cmd, sa(s), 1'b1, 8'h00, 8'h01);
    chk(rbuf[0], 8'h00);
    frame(read_persistent_protect_cmd, sa(s + 7'h01), 1'b1, 8'h00, 8'h01);
    chk(rbuf[0], 8'hff);
    wen();
    frame(erase_persistent_protect_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    frame(read_persistent_protect_cmd, sa(s), 1'b1, 8'h00, 8'h01);
    chk(rbuf[0], 8'hff);
    $display("persistent test done");
    frame(clear_protect_lock_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    frame(read_protect_lock_cmd, 32'h0, 1'b0, 8'h00, 8'h02);
    chk(rbuf[1], 8'h01);
    wen();
    frame(clear_protect_lock_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    frame(read_protect_lock_cmd, 32'h0, 1'b0, 8'h00, 8'h01);
    chk(rbuf[0], 8'h00);
    wen();
    frame(program_persistent_protect_cmd, sa(s), 1'b1, 8'h00, 8'h00);
    frame(read_persistent_protect_cmd, sa(s), 1'b1, 8'h00, 8'h01);
    chk(rbuf[0], 8'hff);
    for (int i = 0; i < 8; i++) wbuf[i] = HIDDEN_PASSWORD[8 * i +: 8];
    frame(password_unlock_cmd, 32'h0, 1'b0, 8'h08, 8'h00);
    chk({6'h00, lockout_o, lock_bit_o}, 8'h01);
    $display("lock test done");
    a = {22'h0, 10'(rnd()) & 10'h3f8};
    for (int i = 0; i < 4; i++) wbuf[i] = 8'(rnd());
    wen();
    frame(program_secure_region_cmd, a, 1'b1, 8'h04, 8'h00);
    frame(read_secure_region_cmd, a, 1'b1, 8'h00, 8'h04);
    for (int i = 0; i < 4; i++) chk(rbuf[i], wbuf[i]);
    $display("secure region test done");
    op_busy_i <= 1'b1;
    frame(suspend_operation_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    chk({7'h00, suspended_o}, 8'h01);
    frame(resume_operation_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    chk({7'h00, suspended_o}, 8'h00);
    op_busy_i <= 1'b0;
    frame(suspend_operation_cmd, 32'h0, 1'b0, 8'h00, 8'h00);
    chk({7'h00, suspended_o}, 8'h00);
    $display("suspend test done");
    // wrong password: upper half inverted, lower half keeps the secure data
    for (int i = 4; i < 8; i++) wbuf[i] = ~HIDDEN_PASSWORD[8 * i +: 8];
    frame(password_unlock_cmd, 32'h0, 1'b0, 8'h08, 8'h00);
    chk({6'h00, lockout_o, lock_bit_o}, 8'h03);
    wen();
    chk({7'h00, wel_o}, 8'h00);
    // only a reset lifts the lockout; the secure region survives it
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({4'h0, wel_o, suspended_o, lockout_o, lock_bit_o}, 8'h01);
    frame(read_secure_region_cmd, a, 1'b1, 8'h00, 8'h04);
    for (int i = 0; i < 4; i++) chk(rbuf[i], wbuf[i]);
    $display("lockout and reset test done");
    close_out();
  end
endmodule
